//--- core/sleep_mode_power_control.sv
`timescale 1ns/100ps
`default_nettype none

module sleep_mode_power_control
    import pwr_pkg::*;
#(
    parameter logic [7:0] CHANGE_SIGNATURE = 8'h5A, // arbitrary value
    parameter int OSC_CYCLES = OSC_STARTUP_CYCLES,
    parameter int HALT_CYCLES = WAKE_HALT_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire logic sleep_instr_in,
    input wire logic ext_level_int_in,
    input wire logic ext_edge_int_in,
    input wire logic pin_change_int_in,
    input wire logic converter_int_in,
    input wire logic other_io_int_in,
    input wire logic watchdog_int_in,
    input wire logic supply_monitor_int_in,
    input wire logic watchdog_reset_in,
    input wire logic watchdog_enabled_in,
    input wire logic converter_enabled_in,
    input wire logic conversion_started_in,
    output logic cpu_clock_en_out,
    output logic nvm_clock_en_out,
    output logic io_clock_en_out,
    output logic converter_clock_en_out,
    output logic timer_clock_en_out,
    output logic oscillator_en_out,
    output logic [3:0] system_clock_divide_select_out,
    output logic timer_access_block_out,
    output logic converter_access_block_out,
    output logic converter_start_out,
    output logic extended_conversion_out,
    output logic comparator_disable_out,
    output logic input_buffer_disable_out,
    output logic watchdog_run_out,
    output logic handler_entry_out,
    output logic reset_vector_out,
    output logic sleeping_out
);
    ctrl_state_type st_reg;
    ctrl_state_type st_next;
    logic take;
    logic wr_ccp;
    logic wr_system_clock_divide_select;
    logic mode_valid;
    logic wake_irq;
    logic sleep_go;
    logic waking;
    logic [NUM_DOMAINS-1:0] keep;
    logic [NUM_DOMAINS-1:0] block;
    logic [NUM_DOMAINS-1:0] dom_en;

    window_if win ();

    generate
        if (OSC_CYCLES < 1 || OSC_CYCLES > 15 || HALT_CYCLES < 1 || HALT_CYCLES > 15) begin : gen_bad_counts
            $error("wake counts out of range");
        end
    endgenerate

    protect_window #(
        .WINDOW_CYCLES(CHANGE_WINDOW_CYCLES)
    ) u_window (
        .core_clk_in(core_clk_in),
        .resetn_in(resetn_in),
        .win(win)
    );

    function automatic logic [31:0] reg_read(input logic [31:0] addr, input ctrl_state_type s, input logic act);
        logic [31:0] d;
        d = 32'h0;
        if (addr[31:10] == 22'h0) begin
            case (addr[9:2])
                IDX_SLEEP_MODE_CONTROL: d[3:0] = s.sleep_mode_control;
                IDX_POWER_REDUCTION: d[1:0] = s.power_reduction_bits;
                IDX_CLOCK_PRESCALE: d[3:0] = s.system_clock_divide_select;
                IDX_POWER_STATUS: begin
                    d[STATUS_ASLEEP_POS] = (s.state != ST_RUN);
                    d[STATUS_WINDOW_POS] = act;
                    d[STATUS_EXTENDED_POS] = s.ext_conv;
                end
                default: d = 32'h0;
            endcase
        end
        return d;
    endfunction

    // bus slave: zero wait states, always OKAY
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign take = hsel_in & hready_in & htrans_in[1];

    assign wr_ccp = st_reg.wr_pend & (st_reg.wr_idx == IDX_CONFIG_CHANGE_PROTECT)
        & (hwdata_in[7:0] == CHANGE_SIGNATURE);
    assign wr_system_clock_divide_select = st_reg.wr_pend & (st_reg.wr_idx == IDX_CLOCK_PRESCALE) & win.active;
    assign win.open = wr_ccp;
    assign win.consume = wr_system_clock_divide_select;

    assign mode_valid = (st_reg.sleep_mode_control[3:1] == MODE_IDLE) | (st_reg.sleep_mode_control[3:1] == MODE_NOISE_REDUCTION)
        | (st_reg.sleep_mode_control[3:1] == MODE_POWER_DOWN) | (st_reg.sleep_mode_control[3:1] == MODE_STANDBY);
    // sleep only with enable set; reserved code keeps running
    assign sleep_go = (st_reg.state == ST_RUN) & sleep_instr_in & st_reg.sleep_mode_control[SLEEP_ENABLE_BIT_POS] & mode_valid;

    // wake sources per mode; power-down and standby sources
    always_comb begin
        case (st_reg.mode)
            MODE_IDLE: wake_irq = ext_level_int_in | ext_edge_int_in | pin_change_int_in | converter_int_in
                | other_io_int_in | watchdog_int_in | supply_monitor_int_in;
            MODE_NOISE_REDUCTION: wake_irq = ext_level_int_in | pin_change_int_in | converter_int_in
                | watchdog_int_in | supply_monitor_int_in;
            default: wake_irq = ext_level_int_in | pin_change_int_in | watchdog_int_in;
        endcase
    end
    assign waking = (st_reg.state == ST_SLEEP) & (wake_irq | watchdog_reset_in);

    always_comb begin
        st_next = st_reg;
        st_next.conv_start = 1'b0;
        st_next.handler = 1'b0;
        st_next.reset_vec = 1'b0;
        st_next.wr_pend = take & hwrite_in & (haddr_in[31:10] == 22'h0);
        st_next.wr_idx = haddr_in[9:2];
        st_next.rdata = (take & ~hwrite_in) ? reg_read(haddr_in, st_reg, win.active) : 32'h0;
        if (st_reg.wr_pend) begin
            case (st_reg.wr_idx)
                IDX_SLEEP_MODE_CONTROL: st_next.sleep_mode_control = hwdata_in[3:0];
                IDX_POWER_REDUCTION: st_next.power_reduction_bits = hwdata_in[1:0];
                default: st_next.sleep_mode_control = st_reg.sleep_mode_control;
            endcase
        end
        if (wr_system_clock_divide_select) begin
            st_next.system_clock_divide_select = hwdata_in[3:0];
        end
        case (st_reg.state)
            ST_RUN: begin
                if (sleep_go) begin
                    st_next.state = ST_SLEEP;
                    st_next.mode = st_reg.sleep_mode_control[3:1];
                    st_next.conv_start = converter_enabled_in
                        & ((st_reg.sleep_mode_control[3:1] == MODE_IDLE) | (st_reg.sleep_mode_control[3:1] == MODE_NOISE_REDUCTION));
                end
            end
            ST_SLEEP: begin
                if (waking) begin
                    st_next.reset_wake = watchdog_reset_in;
                    // no start-up delay unless the oscillator was stopped
                    if (st_reg.mode == MODE_POWER_DOWN) begin
                        st_next.state = ST_OSC_START;
                        st_next.cnt = 4'(OSC_CYCLES - 1);
                    end else begin
                        st_next.state = ST_WAKE_HALT;
                        st_next.cnt = 4'(HALT_CYCLES - 1);
                    end
                end
            end
            ST_OSC_START: begin
                if (st_reg.cnt == 4'h0) begin
                    st_next.state = ST_WAKE_HALT;
                    st_next.cnt = 4'(HALT_CYCLES - 1);
                end else begin
                    st_next.cnt = st_reg.cnt - 4'h1;
                end
            end
            ST_WAKE_HALT: begin
                if (st_reg.cnt == 4'h0) begin
                    st_next.state = ST_RUN;
                    st_next.handler = ~st_reg.reset_wake;
                    st_next.reset_vec = st_reg.reset_wake;
                    st_next.reset_wake = 1'b0;
                end else begin
                    st_next.cnt = st_reg.cnt - 4'h1;
                end
            end
            default: st_next.state = ST_RUN;
        endcase
        // extended conversion; a new enable wins over a start
        st_next.conv_en_prev = converter_enabled_in;
        if (converter_enabled_in & ~st_reg.conv_en_prev) begin
            st_next.ext_conv = 1'b1;
        end else if (conversion_started_in | st_reg.conv_start) begin
            st_next.ext_conv = 1'b0;
        end
        st_next.wdt_run = watchdog_enabled_in;
        st_next.cmp_off = (st_next.state == ST_SLEEP) & (st_next.mode == MODE_POWER_DOWN);
        // input buffers off while io clock stopped
        st_next.ibuf_dis = (st_next.state == ST_SLEEP) & (st_next.mode != MODE_IDLE);
    end

    // clock domains follow the next state
    always_comb begin
        keep[DOM_CPU] = (st_next.state == ST_RUN);
        keep[DOM_NVM] = (st_next.state == ST_RUN);
        keep[DOM_IO] = (st_next.state != ST_SLEEP) | (st_next.mode == MODE_IDLE);
        keep[DOM_CONVERTER] = (st_next.state != ST_SLEEP) | (st_next.mode == MODE_IDLE)
            | (st_next.mode == MODE_NOISE_REDUCTION);
        keep[DOM_TIMER] = keep[DOM_IO];
        keep[DOM_OSC] = ~((st_next.state == ST_SLEEP) & (st_next.mode == MODE_POWER_DOWN));
        block = '0;
        // gate bits stop the peripheral clocks; frozen state resumes
        block[DOM_CONVERTER] = st_next.power_reduction_bits[CONVERTER_CLOCK_GATE_POS];
        block[DOM_TIMER] = st_next.power_reduction_bits[TIMER_CLOCK_GATE_POS];
    end

    genvar g;
    generate
        for (g = 0; g < NUM_DOMAINS; g++) begin : gen_gate
            domain_gate u_gate (
                .core_clk_in(core_clk_in),
                .resetn_in(resetn_in),
                .keep_in(keep[g]),
                .block_in(block[g]),
                .enable_out(dom_en[g])
            );
        end
    endgenerate

    // no storage is cleared on sleep, only clocks are stopped
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_reg <= '0;
            st_reg.state <= ST_RUN;
            st_reg.sleep_mode_control <= SLEEP_MODE_CONTROL_RESET;
            st_reg.power_reduction_bits <= POWER_REDUCTION_RESET;
            st_reg.system_clock_divide_select <= CLOCK_DIVIDE_SELECT_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign hrdata_out = st_reg.rdata;
    assign cpu_clock_en_out = dom_en[DOM_CPU];
    assign nvm_clock_en_out = dom_en[DOM_NVM];
    assign io_clock_en_out = dom_en[DOM_IO];
    assign converter_clock_en_out = dom_en[DOM_CONVERTER];
    assign timer_clock_en_out = dom_en[DOM_TIMER];
    assign oscillator_en_out = dom_en[DOM_OSC];
    assign system_clock_divide_select_out = st_reg.system_clock_divide_select;
    assign timer_access_block_out = st_reg.power_reduction_bits[TIMER_CLOCK_GATE_POS];
    assign converter_access_block_out = st_reg.power_reduction_bits[CONVERTER_CLOCK_GATE_POS];
    assign converter_start_out = st_reg.conv_start;
    assign extended_conversion_out = st_reg.ext_conv;
    assign comparator_disable_out = st_reg.cmp_off;
    assign input_buffer_disable_out = st_reg.ibuf_dis;
    assign watchdog_run_out = st_reg.wdt_run;
    assign handler_entry_out = st_reg.handler;
    assign reset_vector_out = st_reg.reset_vec;
    assign sleeping_out = (st_reg.state != ST_RUN);

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);

    prescale_reset_a: assert property ($rose(resetn_in) |-> st_reg.system_clock_divide_select == CLOCK_DIVIDE_SELECT_RESET)
        else $error("divide select not 8 after reset");
    window_gate_a: assert property (st_reg.system_clock_divide_select != $past(st_reg.system_clock_divide_select) |-> $past(win.active))
        else $error("prescale changed outside window");
    sleep_entry_a: assert property (sleep_go |=> st_reg.state == ST_SLEEP && !cpu_clock_en_out)
        else $error("sleep not entered");
    reserved_mode_a: assert property ((st_reg.state == ST_RUN) && sleep_instr_in && !mode_valid
        |=> cpu_clock_en_out && io_clock_en_out && oscillator_en_out)
        else $error("reserved mode stopped a clock");
    idle_clocks_a: assert property ((st_reg.state == ST_SLEEP) && (st_reg.mode == MODE_IDLE)
        |-> !cpu_clock_en_out && !nvm_clock_en_out && io_clock_en_out)
        else $error("idle clock set wrong");
    noise_clocks_a: assert property ((st_reg.state == ST_SLEEP) && (st_reg.mode == MODE_NOISE_REDUCTION)
        |-> !io_clock_en_out && !cpu_clock_en_out && converter_clock_en_out == !st_reg.power_reduction_bits[1])
        else $error("noise reduction clock set wrong");
    power_down_a: assert property ((st_reg.state == ST_SLEEP) && (st_reg.mode == MODE_POWER_DOWN)
        |-> !oscillator_en_out && !io_clock_en_out && comparator_disable_out)
        else $error("power-down left something running");
    standby_osc_a: assert property ((st_reg.state == ST_SLEEP) && (st_reg.mode == MODE_STANDBY)
        |-> oscillator_en_out && !io_clock_en_out && input_buffer_disable_out)
        else $error("standby oscillator wrong");
    idle_wake_a: assert property (waking && (st_reg.mode == MODE_IDLE) && !watchdog_reset_in
        |=> (!cpu_clock_en_out) [*4] ##1 (cpu_clock_en_out && handler_entry_out))
        else $error("idle wake timing wrong");
    pd_wake_a: assert property (waking && (st_reg.mode == MODE_POWER_DOWN)
        |=> (!cpu_clock_en_out) [*8] ##1 (!cpu_clock_en_out) [*2] ##1 cpu_clock_en_out)
        else $error("power-down wake timing wrong");
    reset_wake_a: assert property (waking && watchdog_reset_in && (st_reg.mode == MODE_POWER_DOWN)
        |-> ##11 reset_vector_out && !handler_entry_out)
        else $error("reset wake not to reset vector");
    timer_gate_a: assert property (st_reg.power_reduction_bits[0] |-> !timer_clock_en_out && timer_access_block_out)
        else $error("timer clock not gated");

    idle_entry_c: cover property (sleep_go && st_reg.sleep_mode_control[3:1] == MODE_IDLE ##1 converter_start_out);
    pd_wake_c: cover property (waking && st_reg.mode == MODE_POWER_DOWN);
    prescale_write_c: cover property (wr_system_clock_divide_select);
    reset_wake_c: cover property (reset_vector_out);
endmodule // sleep_mode_power_control

`default_nettype wire

//--- core/pwr_pkg.sv
package pwr_pkg;

    // register word indices; byte address is four times the index
    localparam logic [7:0] IDX_POWER_REDUCTION = 8'h35;
    localparam logic [7:0] IDX_CLOCK_PRESCALE = 8'h36;
    localparam logic [7:0] IDX_SLEEP_MODE_CONTROL = 8'h3A;
    localparam logic [7:0] IDX_CONFIG_CHANGE_PROTECT = 8'h3C;
    localparam logic [7:0] IDX_POWER_STATUS = 8'h3D;

    // sleep_mode_control fields
    localparam int SLEEP_ENABLE_BIT_POS = 0;
    localparam int SLEEP_MODE_SELECT_LSB = 1;
    localparam logic [3:0] SLEEP_MODE_CONTROL_RESET = 4'h0;

    // sleep_mode_select codes
    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_NOISE_REDUCTION = 3'h1;
    localparam logic [2:0] MODE_POWER_DOWN = 3'h2;
    localparam logic [2:0] MODE_STANDBY = 3'h4;

    // power_reduction_bits fields
    localparam int TIMER_CLOCK_GATE_POS = 0;
    localparam int CONVERTER_CLOCK_GATE_POS = 1;
    localparam logic [1:0] POWER_REDUCTION_RESET = 2'h0;

    // clock_prescale_register: divide by 8 after reset
    localparam logic [3:0] CLOCK_DIVIDE_SELECT_RESET = 4'h3;

    // power status fields
    localparam int STATUS_ASLEEP_POS = 0;
    localparam int STATUS_WINDOW_POS = 1;
    localparam int STATUS_EXTENDED_POS = 2;

    // timing counts in main clock cycles
    localparam int CHANGE_WINDOW_CYCLES = 4;
    localparam int OSC_STARTUP_CYCLES = 6;
    localparam int WAKE_HALT_CYCLES = 4;

    // clock domain slots
    localparam int DOM_CPU = 0;
    localparam int DOM_NVM = 1;
    localparam int DOM_IO = 2;
    localparam int DOM_CONVERTER = 3;
    localparam int DOM_TIMER = 4;
    localparam int DOM_OSC = 5;
    localparam int NUM_DOMAINS = 6;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_SLEEP,
        ST_OSC_START,
        ST_WAKE_HALT
    } pwr_state_type;

    typedef struct packed {
        pwr_state_type state;
        logic [2:0] mode;
        logic [3:0] cnt;
        logic reset_wake;
        logic wr_pend;
        logic [7:0] wr_idx;
        logic [31:0] rdata;
        logic [3:0] sleep_mode_control;
        logic [1:0] power_reduction_bits;
        logic [3:0] system_clock_divide_select;
        logic conv_en_prev;
        logic ext_conv;
        logic conv_start;
        logic handler;
        logic reset_vec;
        logic wdt_run;
        logic cmp_off;
        logic ibuf_dis;
    } ctrl_state_type;

endpackage

//--- core/window_if.sv
`timescale 1ns/100ps
`default_nettype none

interface window_if;
    logic open;
    logic consume;
    logic active;
    modport ctrl (output open, output consume, input active);
    modport timer (input open, input consume, output active);
endinterface // window_if

`default_nettype wire

//--- core/protect_window.sv
`timescale 1ns/100ps
`default_nettype none

module protect_window
    import pwr_pkg::*;
#(
    parameter int WINDOW_CYCLES = CHANGE_WINDOW_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    window_if.timer win
);
    typedef struct packed {
        logic [3:0] left;
    } win_state_type;

    win_state_type st_reg;
    win_state_type st_next;

    generate
        if (WINDOW_CYCLES < 1 || WINDOW_CYCLES > 15) begin : gen_bad_window
            $error("window length out of range");
        end
    endgenerate

    always_comb begin
        st_next = st_reg;
        if (win.open) begin
            st_next.left = 4'(WINDOW_CYCLES);
        end else if (win.consume) begin
            st_next.left = 4'h0;
        end else if (st_reg.left != 4'h0) begin
            st_next.left = st_reg.left - 4'h1;
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign win.active = (st_reg.left != 4'h0);
endmodule // protect_window

`default_nettype wire

//--- core/domain_gate.sv
`timescale 1ns/100ps
`default_nettype none

module domain_gate (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic keep_in,
    input wire logic block_in,
    output logic enable_out
);
    typedef struct packed {
        logic en;
    } gate_state_type;

    gate_state_type st_reg;
    gate_state_type st_next;

    // registered so the enable never glitches mid-cycle
    always_comb begin
        st_next.en = keep_in & ~block_in;
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_reg <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign enable_out = st_reg.en;
endmodule // domain_gate

`default_nettype wire

//--- sim/core_model.sv
`timescale 1ns/100ps
`default_nettype none

module core_model (
    input wire logic clk_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_in,
    output logic [31:0] haddr_out,
    output logic [1:0] htrans_out,
    output logic hwrite_out,
    output logic [31:0] hwdata_out,
    output logic sleep_out,
    output logic rvalid_out,
    output logic [31:0] rdata_out
);
    initial begin
        haddr_out = 32'h0;
        htrans_out = 2'h0;
        hwrite_out = 1'b0;
        hwdata_out = 32'h0;
        sleep_out = 1'b0;
        rvalid_out = 1'b0;
        rdata_out = 32'h0;
    end
    always @(posedge clk_in) if (rvalid_out) rvalid_out <= 1'b0;
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge clk_in);
        htrans_out <= 2'h2;
        haddr_out <= {22'h0, idx, 2'h0};
        hwrite_out <= wr;
        // released data lines never keep the last value
        hwdata_out <= ~hwdata_out;
        do @(posedge clk_in); while (hready_in !== 1'b1);
        htrans_out <= 2'h0;
        hwdata_out <= wd;
        do @(posedge clk_in); while (hready_in !== 1'b1);
        rdata_out <= hrdata_in;
        rvalid_out <= !wr;
    endtask
    task automatic sleep_instr();
        @(posedge clk_in);
        sleep_out <= 1'b1;
        @(posedge clk_in);
        sleep_out <= 1'b0;
    endtask
endmodule // core_model

`default_nettype wire

//--- sim/sleep_mode_power_control_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module sleep_mode_power_control_tb_top;
    import pwr_pkg::*;
    localparam logic [7:0] SIG = 8'h5A; // arbitrary value
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [6:0] irq = 7'h0;
    logic wdt_rst = 1'b0;
    logic wdt_en = 1'b1;
    logic conv_en = 1'b1;
    logic conv_go = 1'b0;
    logic [15:0] lfsr = 16'hC460;
    logic [3:0] v;
    int err_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int n;
    logic [31:0] exp_q[$];
    logic [2:0] modes [4] = '{MODE_IDLE, MODE_NOISE_REDUCTION, MODE_STANDBY, MODE_POWER_DOWN};
    logic [4:0] dom [4] = '{5'h1D, 5'h0F, 5'h06, 5'h02};
    int src [4] = '{4, 3, 2, 0};
    wire logic [31:0] haddr, hwdata, hrdata, rdata;
    wire logic [1:0] htrans;
    wire logic hwrite, hready, sleep, rvalid, hresp;
    wire logic cpu_en, nvm_en, io_en, cv_en, tm_en, osc_en, tm_blk, cv_blk, cv_st, ext_cv;
    wire logic cmp_dis, ibuf, wdt_run, hnd, rvec, slp;
    wire logic [3:0] div;

    initial forever #4 clk = ~clk;

    core_model u_core_model (.clk_in(clk), .hready_in(hready), .hrdata_in(hrdata), .haddr_out(haddr),
        .htrans_out(htrans), .hwrite_out(hwrite), .hwdata_out(hwdata), .sleep_out(sleep),
        .rvalid_out(rvalid), .rdata_out(rdata));

    sleep_mode_power_control #(.CHANGE_SIGNATURE(SIG)) u_sleep_mode_power_control (.core_clk_in(clk),
        .resetn_in(rstn), .hsel_in(1'b1), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
        .hresp_out(hresp), .sleep_instr_in(sleep), .ext_level_int_in(irq[0]), .ext_edge_int_in(irq[1]),
        .pin_change_int_in(irq[2]), .converter_int_in(irq[3]), .other_io_int_in(irq[4]),
        .watchdog_int_in(irq[5]), .supply_monitor_int_in(irq[6]), .watchdog_reset_in(wdt_rst),
        .watchdog_enabled_in(wdt_en), .converter_enabled_in(conv_en), .conversion_started_in(conv_go),
        .cpu_clock_en_out(cpu_en), .nvm_clock_en_out(nvm_en), .io_clock_en_out(io_en),
        .converter_clock_en_out(cv_en), .timer_clock_en_out(tm_en), .oscillator_en_out(osc_en),
        .system_clock_divide_select_out(div), .timer_access_block_out(tm_blk),
        .converter_access_block_out(cv_blk), .converter_start_out(cv_st), .extended_conversion_out(ext_cv),
        .comparator_disable_out(cmp_dis), .input_buffer_disable_out(ibuf), .watchdog_run_out(wdt_run),
        .handler_entry_out(hnd), .reset_vector_out(rvec), .sleeping_out(slp));

    task automatic stop_test();
        if (err_count == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        exp_q.push_back(exp);
        u_core_model.xfer(1'b0, idx, 32'h0);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        u_core_model.xfer(1'b1, idx, d);
    endtask
    function automatic logic [15:0] lfsr_step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // counts edges until a one-cycle pulse shows, bounded
    task automatic wait_pulse(input logic use_rvec);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while ((use_rvec ? rvec : hnd) !== 1'b1 && n < 40);
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc > 6000) begin
            err_count++;
            stop_test();
        end
        if (rvalid === 1'b1) chk(rdata, exp_q.size() ? exp_q.pop_front() : 32'hFFFFFFFF);
    end

    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        chk(32'(div), 32'h3);
        chk(32'({hresp, hready}), 32'h1);
        rd(IDX_SLEEP_MODE_CONTROL, 32'h0);
        rd(IDX_CLOCK_PRESCALE, 32'h3);
        rd(8'h10, 32'h0);
        lfsr = lfsr_step(lfsr);
        v = {1'b0, lfsr[2:0]} | 4'h4;
        wr(IDX_CLOCK_PRESCALE, 32'(v));
        rd(IDX_CLOCK_PRESCALE, 32'h3);
        // interrupts stay low through the change
        wr(IDX_CONFIG_CHANGE_PROTECT, 32'(SIG));
        wr(IDX_CLOCK_PRESCALE, 32'(v));
        rd(IDX_CLOCK_PRESCALE, 32'(v));
        chk(32'(div), 32'(v));
        wr(IDX_CONFIG_CHANGE_PROTECT, 32'(SIG));
        repeat (4) @(posedge clk);
        wr(IDX_CLOCK_PRESCALE, 32'h0);
        rd(IDX_CLOCK_PRESCALE, 32'(v));
        wr(IDX_POWER_REDUCTION, 32'h3);
        repeat (2) @(posedge clk);
        chk(32'({tm_en, cv_en, tm_blk, cv_blk}), 32'h3);
        rd(IDX_POWER_REDUCTION, 32'h3);
        wr(IDX_POWER_REDUCTION, 32'h0);
        repeat (2) @(posedge clk);
        chk(32'({tm_en, cv_en, tm_blk, cv_blk}), 32'hC);
        wr(IDX_SLEEP_MODE_CONTROL, {28'h0, MODE_IDLE, 1'b0});
        u_core_model.sleep_instr();
        #1 chk(32'({slp, cpu_en}), 32'h1);
        wr(IDX_SLEEP_MODE_CONTROL, 32'h7);
        u_core_model.sleep_instr();
        #1 chk(32'({slp, cpu_en, nvm_en, io_en}), 32'h7);
        for (int i = 0; i < 4; i++) begin
            wr(IDX_SLEEP_MODE_CONTROL, {28'h0, modes[i], 1'b1});
            u_core_model.sleep_instr();
            #1 chk({slp, cpu_en, nvm_en, io_en, cv_en, osc_en, ibuf, cv_st}, {3'h4, dom[i]});
            chk(32'({cmp_dis, wdt_run}), {30'h0, modes[i] == MODE_POWER_DOWN, 1'b1});
            if (i == 3) begin
                @(posedge clk);
                irq <= 7'h0A;
                repeat (4) @(posedge clk);
                irq <= 7'h0;
                #1 chk(32'(slp), 32'h1);
            end
            @(posedge clk);
            irq[src[i]] <= 1'b1;
            wait_pulse(1'b0);
            chk(32'(n), 32'(1 + WAKE_HALT_CYCLES + (i == 3 ? OSC_STARTUP_CYCLES : 0)));
            chk(32'({slp, cpu_en, rvec}), 32'h2);
            @(posedge clk);
            irq <= 7'h0;
        end
        wr(IDX_SLEEP_MODE_CONTROL, {28'h0, MODE_POWER_DOWN, 1'b1});
        u_core_model.sleep_instr();
        @(posedge clk);
        wdt_rst <= 1'b1;
        wait_pulse(1'b1);
        chk(32'({rvec, hnd, slp}), 32'h4);
        @(posedge clk);
        wdt_rst <= 1'b0;
        conv_go <= 1'b1;
        conv_en <= 1'b0;
        wdt_en <= 1'b0;
        @(posedge clk);
        conv_go <= 1'b0;
        conv_en <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk(32'(ext_cv), 32'h1);
        @(posedge clk);
        conv_go <= 1'b1;
        @(posedge clk);
        conv_go <= 1'b0;
        repeat (3) @(posedge clk);
        chk(32'({ext_cv, wdt_run}), 32'h0);
        chk(32'(exp_q.size()), 32'h0);
        // mid-run reset brings the divider back to 8
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        #1 chk(32'(div), 32'h3);
        stop_test();
    end
endmodule // sleep_mode_power_control_tb_top

`default_nettype wire
